// file: hdl/wdslp_pkg.sv
// package: constants for the watchdog and sleep control block
package wdslp_pkg;
    // ------------------------------------------------------------
    // register map (word addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] WDSLP_ADDR_OPTION = 4'h0;
    localparam logic [3:0] WDSLP_ADDR_STATUS = 4'h1;
    localparam logic [3:0] WDSLP_ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] WDSLP_ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] WDSLP_ADDR_ID_BASE = 4'h4;
    localparam logic [3:0] WDSLP_ADDR_PROG_DATA = 4'h8;
    localparam logic [3:0] WDSLP_ADDR_PROG_ADDR = 4'h9;
    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] WDSLP_OPTION_RESET = 6'h3F;
    localparam int WDSLP_OPT_PSA = 3;
    localparam int WDSLP_STAT_TO = 4;
    localparam int WDSLP_STAT_PD = 3;
    localparam int WDSLP_CFG_WATCHDOG_ENABLE_FUSE = 2;
    localparam int WDSLP_CFG_CP_LSB = 3;
    localparam int WDSLP_ID_COUNT = 4;
    localparam logic [11:0] WDSLP_ID_RESET = 12'hFFF;
    localparam int WDSLP_IRQ_W = 3;
    localparam int WDSLP_IRQ_TIMEOUT = 0;
    localparam int WDSLP_IRQ_SLEEP = 1;
    localparam int WDSLP_IRQ_WAKE = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int WDSLP_TIMEOUT_US = 18000;
    localparam int WDSLP_WDT_OSC_KHZ = 200000;
    // divide first: the plain product would overflow a 32-bit int
    localparam int WDSLP_TIMEOUT_CYC = WDSLP_TIMEOUT_US *
                                       (WDSLP_WDT_OSC_KHZ / 1000);
    typedef enum logic [1:0] {
        WDSLP_RUN = 2'b01,
        WDSLP_SLEEP = 2'b10
    } wdslp_state_e;
endpackage

// file: hdl/wdslp_top.sv
// watchdog timer, power-down control, verify gating and id words
`timescale 1ns/1ps
`default_nettype none
// Function
// - clear-watchdog zeroes counter and prescaler when prescaler serves watchdog
// - sleep zeroes counter and assigned prescaler for full period
// - sleep enters power-down; watchdog keeps counting when enabled
// - sleep sets timeout flag, clears powerdown flag, stops oscillator driver
// - pins hold their pre-sleep state during power-down
// - watchdog reset stays internal, master clear pin never driven low
// - wake only on master clear or enabled watchdog timeout, full reset
// - watchdog timeout clears the timeout flag
// - powerdown flag set at power-up, cleared only by sleep
// - watchdog counter cleared on wake from power-down
// - six option bits read as ones after every reset
// - program memory readable in verify only when unprotected
// - four id words, accessible only in program/verify mode
// - watchdog disabled when enable fuse is zero
// - one eight-bit prescaler serves timer or watchdog, never both
// - nominal 18 ms timeout, prescaler up to 1:256 for timer, 1:128 for watchdog
// - watchdog timeout resets device in run or sleep
module wdslp_top
    import wdslp_pkg::*;
#(
    parameter int TIMEOUT_CYC = WDSLP_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [11:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [11:0] reg_rdata,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic master_clear_pin_n,
    input wire logic [11:0] config_word,
    input wire logic verify_mode,
    input wire logic [11:0] prog_mem_data,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe_n,
    input wire logic tmr_tick,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic master_clear_oe_n,
    output logic osc_drive_en,
    output logic device_reset,
    output logic tmr_prescaled_tick,
    output logic irq
);
    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function automatic logic [7:0] ratio_mask(input logic [2:0] ps);
        ratio_mask = 8'hFF >> (3'h7 - ps);
    endfunction
    localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);

    wdslp_state_e state_reg, state_next;
    logic [5:0] option_reg;
    logic timeout_flag_reg, powerdown_flag_reg;
    logic [CNT_W-1:0] wdt_cnt_reg;
    logic [7:0] presc_reg;
    logic [WDSLP_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
    logic [11:0] id_reg [WDSLP_ID_COUNT];
    logic [7:0] hold_out_reg, hold_oe_n_reg;
    logic [11:0] reg_rdata_reg;
    logic reset_pulse_reg, tmr_tick_reg;
    logic irq_reg;

    wire logic master_clear_pin_active = ~master_clear_pin_n;
    wire logic wdt_en = config_word[WDSLP_CFG_WATCHDOG_ENABLE_FUSE];
    wire logic prescaler_assign_bit = option_reg[WDSLP_OPT_PSA];
    wire logic [7:0] pmask = ratio_mask(option_reg[2:0]);
    // watchdog ratios run 1:1 to 1:128, one step below the timer's
    wire logic [7:0] wmask = pmask >> 1;
    wire logic sleeping = (state_reg == WDSLP_SLEEP);
    wire logic code_open = &config_word[11:WDSLP_CFG_CP_LSB];
    wire logic run_clr = (state_reg == WDSLP_RUN) &&
                         (clear_watchdog_instr || sleep_instr);
    wire logic cnt_wrap = (wdt_cnt_reg == CNT_LAST);
    // prescaler as watchdog postscaler: fires when its masked bits are full
    wire logic presc_full = ((presc_reg & pmask) == pmask);
    wire logic wdt_full = ((presc_reg & wmask) == wmask);
    wire logic presc_hit = prescaler_assign_bit ? wdt_full : presc_full;
    // a clear in the wrap cycle wins, so a kick is never too late
    wire logic wdt_timeout = wdt_en && cnt_wrap && !run_clr &&
                             (!prescaler_assign_bit || wdt_full);
    wire logic tmr_edge = tmr_tick && !prescaler_assign_bit;
    wire logic tmr_out = prescaler_assign_bit ? tmr_tick : (tmr_edge && presc_full);
    wire logic wake = sleeping && (master_clear_pin_active || wdt_timeout);
    wire logic [WDSLP_IRQ_W-1:0] irq_ev = {wake,
        (state_reg == WDSLP_RUN) && sleep_instr, wdt_timeout};
    wire logic wr_opt = reg_wr && (reg_addr == WDSLP_ADDR_OPTION);
    wire logic wr_istat = reg_wr && (reg_addr == WDSLP_ADDR_IRQ_STAT);
    wire logic wr_imask = reg_wr && (reg_addr == WDSLP_ADDR_IRQ_MASK);
    wire logic id_sel = (reg_addr >= WDSLP_ADDR_ID_BASE) &&
                        (reg_addr < WDSLP_ADDR_PROG_DATA);
    wire logic [1:0] id_idx = reg_addr[1:0];
    logic [11:0] rd_mux;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 12'h000;
        case (reg_addr)
            WDSLP_ADDR_OPTION: rd_mux = {6'h00, option_reg};
            WDSLP_ADDR_STATUS: begin
                rd_mux[WDSLP_STAT_TO] = timeout_flag_reg;
                rd_mux[WDSLP_STAT_PD] = powerdown_flag_reg;
            end
            WDSLP_ADDR_IRQ_STAT: rd_mux = {9'h000, irq_stat_reg};
            WDSLP_ADDR_IRQ_MASK: rd_mux = {9'h000, irq_mask_reg};
            WDSLP_ADDR_PROG_DATA: begin
                if (verify_mode && code_open) begin
                    rd_mux = prog_mem_data;
                end
            end
            default: begin
                if (id_sel && verify_mode) begin
                    rd_mux = id_reg[id_idx];
                end
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WDSLP_RUN: begin
                if (sleep_instr && !master_clear_pin_active) begin
                    state_next = WDSLP_SLEEP;
                end
            end
            WDSLP_SLEEP: begin
                if (wake) begin
                    state_next = WDSLP_RUN;
                end
            end
            default: state_next = WDSLP_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // state, flags and option
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= WDSLP_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // any reset source brings the option back to all ones
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            option_reg <= WDSLP_OPTION_RESET;
        end else if (master_clear_pin_active || wdt_timeout) begin
            option_reg <= WDSLP_OPTION_RESET;
        end else if (wr_opt) begin
            option_reg <= reg_wdata[5:0];
        end
    end

    // timeout clears its flag; a clear or sleep in the same cycle suppresses the timeout
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timeout_flag_reg <= 1'b1;
        end else if (wdt_timeout) begin
            timeout_flag_reg <= 1'b0;
        end else if (run_clr) begin
            timeout_flag_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            powerdown_flag_reg <= 1'b1;
        end else if (sleep_instr && state_reg == WDSLP_RUN) begin
            powerdown_flag_reg <= 1'b0;
        end else if (clear_watchdog_instr && state_reg == WDSLP_RUN) begin
            powerdown_flag_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter and shared prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wdt_cnt_reg <= '0;
            presc_reg <= 8'h00;
        end else begin
            if (run_clr || wake || master_clear_pin_active || !wdt_en) begin
                wdt_cnt_reg <= '0;
            end else if (cnt_wrap) begin
                wdt_cnt_reg <= '0;
            end else begin
                wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
            end
            if (prescaler_assign_bit && (run_clr || wake || master_clear_pin_active)) begin
                presc_reg <= 8'h00;
            end else if (prescaler_assign_bit ? (wdt_en && cnt_wrap) : tmr_edge) begin
                presc_reg <= presc_hit ? 8'h00 : presc_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and id words
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < WDSLP_IRQ_W; i++) begin : g_irq
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    irq_stat_reg[i] <= 1'b0;
                    irq_mask_reg[i] <= 1'b0;
                end else begin
                    // a new event outranks a write-one clear
                    if (irq_ev[i]) begin
                        irq_stat_reg[i] <= 1'b1;
                    end else if (wr_istat && reg_wdata[i]) begin
                        irq_stat_reg[i] <= 1'b0;
                    end
                    if (wr_imask) begin
                        irq_mask_reg[i] <= reg_wdata[i];
                    end
                end
            end
        end
        for (genvar j = 0; j < WDSLP_ID_COUNT; j++) begin : g_id
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    id_reg[j] <= WDSLP_ID_RESET;
                end else if (reg_wr && verify_mode && id_sel &&
                             id_idx == 2'(j)) begin
                    id_reg[j] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    // pins freeze while asleep, holding what they showed before sleep
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_out_reg <= 8'h00;
            hold_oe_n_reg <= 8'hFF;
        end else if (!sleeping) begin
            hold_out_reg <= port_out;
            hold_oe_n_reg <= port_oe_n;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_reg <= 12'h000;
        end else begin
            reg_rdata_reg <= reg_rd ? rd_mux : 12'h000;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reset_pulse_reg <= 1'b0;
        end else begin
            reset_pulse_reg <= wdt_timeout || master_clear_pin_active;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tmr_tick_reg <= 1'b0;
        end else begin
            tmr_tick_reg <= tmr_out;
        end
    end

    // registered, so the level lags a status or mask change by a cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign pin_out = hold_out_reg;
    assign pin_oe_n = hold_oe_n_reg;
    assign osc_drive_en = state_reg[0];
    assign master_clear_oe_n = irq_mask_reg[0] | 1'b1;
    assign device_reset = reset_pulse_reg;
    assign tmr_prescaled_tick = tmr_tick_reg;
    assign irq = irq_reg;
    assign reg_rdata = reg_rdata_reg;
endmodule
`default_nettype wire

// file: testbench/wdslp_monitor.sv
// checker: port assertions for the watchdog and sleep block
`timescale 1ns/1ps
`default_nettype none
module wdslp_monitor
    import wdslp_pkg::*;
#(
    parameter int TIMEOUT_CYC = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic master_clear_pin_n,
    input wire logic [11:0] config_word,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic master_clear_oe_n,
    input wire logic osc_drive_en,
    input wire logic device_reset
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    master_clear_pin_undriven_a: assert property (master_clear_oe_n)
        else $error("master clear pin driven");
    sleep_stops_osc_a: assert property (sleep_instr && osc_drive_en
        |-> ##[1:2] !osc_drive_en) else $error("oscillator still on");
    pins_frozen_a: assert property (!osc_drive_en && !$past(osc_drive_en)
        |-> $stable(pin_out) && $stable(pin_oe_n))
        else $error("pins moved in sleep");
    master_clear_pin_resets_a: assert property (!master_clear_pin_n |=> device_reset)
        else $error("no reset on master clear");
    stays_asleep_a: assert property (!osc_drive_en && master_clear_pin_n
        && !config_word[WDSLP_CFG_WATCHDOG_ENABLE_FUSE] |=> !osc_drive_en)
        else $error("woke without cause");
    wd_off_quiet_a: assert property (!$past(config_word[WDSLP_CFG_WATCHDOG_ENABLE_FUSE])
        && $past(master_clear_pin_n) |-> !device_reset)
        else $error("reset with watchdog off");
    wake_resets_a: assert property ($rose(osc_drive_en)
        |-> (##[0:1] device_reset) or $past(device_reset))
        else $error("wake without reset");
    // a fresh count cannot expire within eight cycles
    clear_holds_off_a: assert property ((sleep_instr || clear_watchdog_instr)
        && osc_drive_en |=> (!device_reset || !$past(master_clear_pin_n))[*8])
        else $error("time-out right after clear");
endmodule
bind wdslp_top wdslp_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) mon (.clock,
    .rstn, .clear_watchdog_instr, .sleep_instr, .master_clear_pin_n,
    .config_word, .pin_out, .pin_oe_n, .master_clear_oe_n,
    .osc_drive_en, .device_reset);
`default_nettype wire

// file: testbench/wdslp_core_model.sv
// core model: issues clear-watchdog and sleep instruction pulses
`timescale 1ns/1ps
`default_nettype none
module wdslp_core_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic osc_drive_en,
    input wire logic kick_en,
    input wire logic [7:0] kick_gap,
    input wire logic sleep_req,
    output logic clear_watchdog_instr,
    output logic sleep_instr
);
    // ------------------------------------------------------------
    // issue logic
    // ------------------------------------------------------------
    logic [7:0] gap_reg;
    logic due;
    assign due = kick_en && osc_drive_en && gap_reg == kick_gap;
    // a stopped core issues nothing, so both pulses need a running clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= 8'h00;
            clear_watchdog_instr <= 1'b0;
            sleep_instr <= 1'b0;
        end else begin
            gap_reg <= (gap_reg == kick_gap) ? 8'h00 : gap_reg + 8'h01;
            clear_watchdog_instr <= due;
            sleep_instr <= sleep_req && osc_drive_en;
        end
    end
endmodule
`default_nettype wire

// file: testbench/wdslp_bench.sv
// testbench: register rows, sleep, wake and watchdog scenarios
`timescale 1ns/1ps
`default_nettype none
module wdslp_bench;
    typedef struct packed {
        logic [3:0] addr;
        logic vm;
        logic [11:0] cfg;
        logic [11:0] mask;
        logic [11:0] exp;
    } wdslp_row_s;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [11:0] reg_wdata = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic master_clear_pin_n = 1'b1;
    logic [11:0] config_word = 12'hFFF;
    logic verify_mode = 1'b0;
    logic [11:0] prog_mem_data = 12'h5A3;
    logic [7:0] port_out = 8'h00;
    logic [7:0] port_oe_n = 8'hFF;
    logic kick_en = 1'b0;
    logic sleep_req = 1'b0;
    logic tmr_tick = 1'b0;
    logic tmr_prescaled_tick;
    int n_tmr = 0;
    int t0;
    logic clear_watchdog_instr, sleep_instr;
    logic [11:0] reg_rdata;
    logic [7:0] pin_out, pin_oe_n;
    logic master_clear_oe_n, osc_drive_en, device_reset, irq;
    int num_errors = 0;
    int n_checks = 0;
    logic [11:0] d;
    wdslp_row_s r;
    wdslp_row_s rows [6] = '{
        '{4'h0, 1'b0, 12'hFFF, 12'h03F, 12'h03F},
        '{4'h1, 1'b0, 12'hFFF, 12'h018, 12'h018},
        '{4'h4, 1'b0, 12'hFFF, 12'hFFF, 12'h000},
        '{4'h7, 1'b1, 12'hFFF, 12'hFFF, 12'hFFF},
        '{4'h8, 1'b1, 12'hFF7, 12'hFFF, 12'h000},
        '{4'hF, 1'b0, 12'hFFF, 12'hFFF, 12'h000}};
    always #2.5 clock = ~clock;
    always @(posedge clock) n_tmr <= n_tmr + int'(tmr_prescaled_tick);
    wdslp_core_model core (.clock, .rstn, .osc_drive_en, .kick_en,
        .kick_gap(8'h08), .sleep_req, .clear_watchdog_instr, .sleep_instr);
    wdslp_top #(.TIMEOUT_CYC(16)) DUT (.clock, .rstn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clear_watchdog_instr,
        .sleep_instr, .master_clear_pin_n, .config_word, .verify_mode,
        .prog_mem_data, .port_out, .port_oe_n, .tmr_tick, .pin_out,
        .pin_oe_n, .master_clear_oe_n, .osc_drive_en, .device_reset,
        .tmr_prescaled_tick, .irq);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [11:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [11:0] m,
                      input logic [11:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    task automatic wait_rst(input int n);
        for (int i = 0; i < n && device_reset !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk({11'h000, device_reset}, 12'h001);
    endtask
    task automatic sleep_go;
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic master_clear_pin_wake;
        master_clear_pin_n <= 1'b0;
        wait_rst(4);
        @(posedge clock);
        master_clear_pin_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk({11'h000, osc_drive_en}, 12'h001);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            verify_mode <= r.vm;
            config_word <= r.cfg;
            rc(r.addr, r.mask, r.exp);
        end
        verify_mode <= 1'b1;
        rc(4'h8, 12'hFFF, 12'h5A3);
        wr(4'h5, 12'hFF5);
        rc(4'h5, 12'hFFF, 12'hFF5);
        verify_mode <= 1'b0;
        wr(4'h5, 12'hFF0);
        verify_mode <= 1'b1;
        rc(4'h5, 12'hFFF, 12'hFF5);
        verify_mode <= 1'b0;
        // kicks keep an unscaled 16-cycle watchdog quiet, then it expires
        kick_en <= 1'b1;
        wr(4'h0, 12'h000);
        repeat (40) @(posedge clock);
        kick_en <= 1'b0;
        wait_rst(40);
        repeat (3) @(posedge clock);
        rc(4'h1, 12'h018, 12'h008);
        rc(4'h0, 12'h03F, 12'h03F);
        port_out <= 8'hA5;
        port_oe_n <= 8'h0F;
        wr(4'h3, 12'h000);
        sleep_go();
        port_out <= 8'h5A;
        port_oe_n <= 8'hF0;
        rc(4'h1, 12'h018, 12'h010);
        chk({11'h000, osc_drive_en}, 12'h000);
        chk({4'h0, pin_out}, 12'h0A5);
        chk({4'h0, pin_oe_n}, 12'h00F);
        chk({11'h000, irq}, 12'h000);
        wr(4'h3, 12'h002);
        @(posedge clock);
        #1 chk({11'h000, irq}, 12'h001);
        wr(4'h2, 12'h002);
        @(posedge clock);
        #1 chk({11'h000, irq}, 12'h000);
        master_clear_pin_wake();
        wr(4'h0, 12'h000);
        sleep_go();
        wait_rst(40);
        repeat (3) @(posedge clock);
        rc(4'h1, 12'h018, 12'h000);
        chk({11'h000, osc_drive_en}, 12'h001);
        config_word <= 12'hFFB;
        wr(4'h0, 12'h000);
        sleep_go();
        repeat (60) @(posedge clock);
        #1 chk({11'h000, osc_drive_en}, 12'h000);
        master_clear_pin_wake();
        config_word <= 12'hFFF;
        rstn <= 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rc(4'h1, 12'h018, 12'h018);
        rc(4'h0, 12'h03F, 12'h03F);
        // timer owns the prescaler at 1:2: eight ticks give four pulses
        kick_en <= 1'b1;
        wr(4'h0, 12'h000);
        t0 = n_tmr;
        tmr_tick <= 1'b1;
        repeat (8) @(posedge clock);
        tmr_tick <= 1'b0;
        repeat (3) @(posedge clock);
        chk(12'(n_tmr - t0), 12'h004);
        test_done();
    end
    initial begin
        #20000;
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
